// ---- char_lcd_pkg.sv ----
package char_lcd_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [3:0] OFF_INSTR  = 4'h0;
   localparam logic [3:0] OFF_DATA   = 4'h4;
   localparam logic [3:0] OFF_CONFIG = 4'h8;

   // ==========================================================
   // Field positions
   localparam int BUSY_BIT    = 7;
   localparam int CFG_DISP    = 0;
   localparam int CFG_CUR     = 1;
   localparam int CFG_BLINK   = 2;
   localparam int CFG_INC     = 3;
   localparam int CFG_SHIFT   = 4;
   localparam int CFG_WIDTH   = 5;
   localparam int CFG_LINES   = 6;
   localparam int CFG_FONT    = 7;
   localparam int CFG_GLYPH   = 8;
   localparam int CFG_OFF_LSB = 16;

   // ==========================================================
   // Address map of the text RAM
   localparam logic [6:0] HOME_ADDR    = 7'h00;
   localparam logic [6:0] ROW2_BASE    = 7'h40;
   localparam logic [6:0] ROW1_LAST_2L = 7'h27;
   localparam logic [6:0] ROW2_LAST_2L = 7'h67;
   localparam logic [6:0] LAST_1L      = 7'h4F;
   localparam logic [6:0] OFF_MAX_2L   = 7'h27;
   localparam logic [6:0] OFF_MAX_1L   = 7'h4F;
   localparam logic [7:0] SPACE_CODE   = 8'h20;
   localparam logic [6:0] TEXT_LAST    = 7'h7F;

   // ==========================================================
   // Duty codes (denominator of the duty factor)
   localparam logic [4:0] DUTY_1L_5X8  = 5'h08;
   localparam logic [4:0] DUTY_1L_5X11 = 5'h0B;
   localparam logic [4:0] DUTY_2L      = 5'h10;

   // ==========================================================
   // Reset values
   localparam logic [4:0] DUTY_RESET  = 5'h08;
   localparam logic       INC_RESET   = 1'b1;
   localparam logic       WIDTH_RESET = 1'b1;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ    = 100;
   localparam int EXEC_NS    = 18500;
   localparam int CLEAR_NS   = 760000;
   localparam int BLINK_MS   = 185;
   localparam logic [16:0] EXEC_CYC = 17'(EXEC_NS * CLK_MHZ / 1000);
   localparam int CLEAR_CYC_DEF = CLEAR_NS * CLK_MHZ / 1000;
   localparam int BLINK_CYC_DEF = BLINK_MS * CLK_MHZ * 1000;

   // ==========================================================
   // Serial frame: select bit then eight payload bits
   localparam logic [3:0] FRAME_LAST = 4'h8;

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_CLEAR = 2'b01,
      PH_BUSY  = 2'b11
   } phase_t;

endpackage

// ---- char_lcd_instruction_decoder.sv ----
`timescale 1ns/1ps
module char_lcd_instruction_decoder #(
   parameter int CLEAR_CYC = char_lcd_pkg::CLEAR_CYC_DEF,
   parameter int BLINK_CYC = char_lcd_pkg::BLINK_CYC_DEF
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        chip_select_n_i,
   input  wire logic        serial_clk_i,
   input  wire logic        serial_in_i,
   input  wire logic        disp_row_i,
   input  wire logic [3:0]  disp_col_i,
   output logic      [7:0]  disp_char_o,
   output logic      [6:0]  cursor_addr_o,
   output logic             display_on_o,
   output logic             cursor_on_o,
   output logic             blink_phase_o,
   output logic      [4:0]  duty_o,
   output logic             busy_flag_o
);

   // ==========================================================
   // Helper functions
   function automatic logic [6:0] step_addr(input logic [6:0] a,
                                            input logic       up,
                                            input logic       two,
                                            input logic       g);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (g)
      begin
         r[6] = 1'b0;
      end
      else if (two)
      begin
         if (up && a == char_lcd_pkg::ROW1_LAST_2L)
            r = char_lcd_pkg::ROW2_BASE;
         else if (up && a == char_lcd_pkg::ROW2_LAST_2L)
            r = char_lcd_pkg::HOME_ADDR;
         else if (!up && a == char_lcd_pkg::HOME_ADDR)
            r = char_lcd_pkg::ROW2_LAST_2L;
         else if (!up && a == char_lcd_pkg::ROW2_BASE)
            r = char_lcd_pkg::ROW1_LAST_2L;
      end
      else
      begin
         if (up && a == char_lcd_pkg::LAST_1L)
            r = char_lcd_pkg::HOME_ADDR;
         else if (!up && a == char_lcd_pkg::HOME_ADDR)
            r = char_lcd_pkg::LAST_1L;
      end
      return r;
   endfunction

   // Offset of the visible window; a left shift raises it
   function automatic logic [6:0] shift_off(input logic [6:0] off,
                                            input logic       left,
                                            input logic       two);
      logic [6:0] lim;
      logic [6:0] r;
      lim = two ? char_lcd_pkg::OFF_MAX_2L : char_lcd_pkg::OFF_MAX_1L;
      if (left)
         r = (off >= lim) ? 7'h00 : off + 7'h01;
      else
         r = (off == 7'h00 || off > lim) ? lim : off - 7'h01;
      return r;
   endfunction

   // ==========================================================
   // State
   typedef struct packed {
      char_lcd_pkg::phase_t phase;
      logic [16:0] wait_cnt;
      logic [6:0]  clr_idx;
      logic [6:0]  ptr;
      logic        glyph_sel;
      logic        inc;
      logic        shift_en;
      logic        disp_on;
      logic        cur_on;
      logic        blink_en;
      logic        width8;
      logic        two_line;
      logic        font;
      logic [4:0]  duty;
      logic [6:0]  disp_off;
      logic        cs_s1;
      logic        cs_s2;
      logic        sck_s1;
      logic        sck_s2;
      logic        sck_d;
      logic        sd_s1;
      logic        sd_s2;
      logic [3:0]  bit_cnt;
      logic [7:0]  shreg;
      logic        ack;
      logic [31:0] rdata;
      logic [24:0] blink_cnt;
      logic        blink_ph;
      logic [7:0]  disp_char;
   } state_t;

   state_t st;
   state_t next_st;

   logic [7:0]  text_ram  [0:127];
   logic [7:0]  glyph_ram [0:63];
   logic        ram_we;
   logic        ram_glyph;
   logic [6:0]  ram_addr;
   logic [7:0]  ram_wdata;
   logic        wb_req;
   logic        ser_fire;
   logic        cmd_valid;
   logic        cmd_rs;
   logic        cmd_read;
   logic [7:0]  cmd_byte;
   logic [7:0]  ram_rbyte;
   logic [6:0]  win_pos;
   logic [6:0]  win_lim;
   logic [6:0]  disp_addr;

   // ==========================================================
   // Command sources
   assign wb_req   = wb_cyc_i & wb_stb_i & ~st.ack;
   assign ser_fire = ~st.cs_s2 & st.sck_s2 & ~st.sck_d
                     & (st.bit_cnt == char_lcd_pkg::FRAME_LAST);

   always_comb
   begin
      cmd_valid = 1'b0;
      cmd_rs    = 1'b0;
      cmd_read  = 1'b0;
      cmd_byte  = 8'h00;
      if (wb_req)
      begin
         // Address picks instruction or data register
         cmd_valid = (wb_adr_i == char_lcd_pkg::OFF_INSTR) ||
                     (wb_adr_i == char_lcd_pkg::OFF_DATA);
         cmd_rs    = (wb_adr_i == char_lcd_pkg::OFF_DATA);
         cmd_read  = ~wb_we_i;
         cmd_byte  = wb_dat_i[7:0];
         if (wb_we_i && !wb_sel_i[0])
            cmd_valid = 1'b0;
      end
      else if (ser_fire)
      begin
         cmd_valid = 1'b1;
         cmd_rs    = st.shreg[7];
         cmd_byte  = {st.shreg[6:0], st.sd_s2};
      end
   end

   assign ram_rbyte = st.glyph_sel ? glyph_ram[st.ptr[5:0]]
                                   : text_ram[st.ptr];

   // Visible position to text RAM address
   assign win_lim   = st.two_line ? char_lcd_pkg::OFF_MAX_2L
                                  : char_lcd_pkg::OFF_MAX_1L;
   assign win_pos   = ({3'h0, disp_col_i} + st.disp_off > win_lim)
                      ? {3'h0, disp_col_i} + st.disp_off - win_lim
                        - 7'h01
                      : {3'h0, disp_col_i} + st.disp_off;
   assign disp_addr = disp_row_i ? char_lcd_pkg::ROW2_BASE + win_pos
                                 : win_pos;

   // ==========================================================
   // Next state
   always_comb
   begin
      next_st   = st;
      ram_we    = 1'b0;
      ram_glyph = st.glyph_sel;
      ram_addr  = st.ptr;
      ram_wdata = cmd_byte;

      next_st.cs_s1  = chip_select_n_i;
      next_st.cs_s2  = st.cs_s1;
      next_st.sck_s1 = serial_clk_i;
      next_st.sck_s2 = st.sck_s1;
      next_st.sck_d  = st.sck_s2;
      next_st.sd_s1  = serial_in_i;
      next_st.sd_s2  = st.sd_s1;

      // Serial shifter
      if (st.cs_s2)
      begin
         next_st.bit_cnt = 4'h0;
      end
      else if (st.sck_s2 && !st.sck_d)
      begin
         next_st.shreg   = {st.shreg[6:0], st.sd_s2};
         next_st.bit_cnt = ser_fire ? 4'h0 : st.bit_cnt + 4'h1;
      end

      // Wishbone answer
      next_st.ack = wb_req;
      if (wb_req)
      begin
         next_st.rdata = 32'h0;
         if (wb_adr_i == char_lcd_pkg::OFF_INSTR)
            next_st.rdata[7:0] = {st.phase != char_lcd_pkg::PH_IDLE,
                                  st.ptr};
         else if (wb_adr_i == char_lcd_pkg::OFF_DATA)
            next_st.rdata[7:0] = ram_rbyte;
         else if (wb_adr_i == char_lcd_pkg::OFF_CONFIG)
         begin
            next_st.rdata[char_lcd_pkg::CFG_DISP]  = st.disp_on;
            next_st.rdata[char_lcd_pkg::CFG_CUR]   = st.cur_on;
            next_st.rdata[char_lcd_pkg::CFG_BLINK] = st.blink_en;
            next_st.rdata[char_lcd_pkg::CFG_INC]   = st.inc;
            next_st.rdata[char_lcd_pkg::CFG_SHIFT] = st.shift_en;
            next_st.rdata[char_lcd_pkg::CFG_WIDTH] = st.width8;
            next_st.rdata[char_lcd_pkg::CFG_LINES] = st.two_line;
            next_st.rdata[char_lcd_pkg::CFG_FONT]  = st.font;
            next_st.rdata[char_lcd_pkg::CFG_GLYPH] = st.glyph_sel;
            next_st.rdata[char_lcd_pkg::CFG_OFF_LSB +: 7] = st.disp_off;
         end
      end

      // Busy sequencing
      case (st.phase)
         char_lcd_pkg::PH_IDLE:
         begin
            next_st.wait_cnt = 17'h0;
         end
         char_lcd_pkg::PH_CLEAR:
         begin
            ram_we           = 1'b1;
            ram_glyph        = 1'b0;
            ram_addr         = st.clr_idx;
            ram_wdata        = char_lcd_pkg::SPACE_CODE;
            next_st.clr_idx  = st.clr_idx + 7'h01;
            next_st.wait_cnt = st.wait_cnt - 17'h1;
            if (st.clr_idx == char_lcd_pkg::TEXT_LAST)
               next_st.phase = char_lcd_pkg::PH_BUSY;
         end
         char_lcd_pkg::PH_BUSY:
         begin
            next_st.wait_cnt = st.wait_cnt - 17'h1;
            if (st.wait_cnt == 17'h0)
               next_st.phase = char_lcd_pkg::PH_IDLE;
         end
         default:
         begin
            next_st.phase = char_lcd_pkg::PH_IDLE;
         end
      endcase

      // Execution; commands during busy are dropped, flag read allowed
      if (cmd_valid && st.phase == char_lcd_pkg::PH_IDLE &&
          !(cmd_read && !cmd_rs))
      begin
         next_st.phase    = char_lcd_pkg::PH_BUSY;
         next_st.wait_cnt = char_lcd_pkg::EXEC_CYC - 17'h1;
         if (cmd_rs)
         begin
            next_st.ptr = step_addr(st.ptr, st.inc, st.two_line,
                                    st.glyph_sel);
            if (cmd_read)
               ram_we = 1'b0;
            else
            begin
               ram_we = 1'b1;
               if (st.shift_en && !st.glyph_sel)
                  next_st.disp_off = shift_off(st.disp_off, st.inc,
                                               st.two_line);
            end
         end
         else
         begin
            casez (cmd_byte)
               8'b1???????:
               begin
                  next_st.ptr       = cmd_byte[6:0];
                  next_st.glyph_sel = 1'b0;
               end
               8'b01??????:
               begin
                  next_st.ptr       = {1'b0, cmd_byte[5:0]};
                  next_st.glyph_sel = 1'b1;
               end
               8'b001?????:
               begin
                  next_st.width8   = cmd_byte[4];
                  next_st.two_line = cmd_byte[3];
                  next_st.font     = cmd_byte[2];
                  next_st.disp_off = 7'h00;
                  if (cmd_byte[3])
                     next_st.duty = char_lcd_pkg::DUTY_2L;
                  else if (cmd_byte[2])
                     next_st.duty = char_lcd_pkg::DUTY_1L_5X11;
                  else
                     next_st.duty = char_lcd_pkg::DUTY_1L_5X8;
               end
               8'b0001????:
               begin
                  if (cmd_byte[3])
                     next_st.disp_off = shift_off(st.disp_off,
                                                  ~cmd_byte[2],
                                                  st.two_line);
                  else
                     next_st.ptr = step_addr(st.ptr, cmd_byte[2],
                                             st.two_line,
                                             st.glyph_sel);
               end
               8'b00001???:
               begin
                  next_st.disp_on  = cmd_byte[2];
                  next_st.cur_on   = cmd_byte[1];
                  next_st.blink_en = cmd_byte[0];
               end
               8'b000001??:
               begin
                  next_st.inc      = cmd_byte[1];
                  next_st.shift_en = cmd_byte[0];
               end
               8'b0000001?:
               begin
                  next_st.ptr       = char_lcd_pkg::HOME_ADDR;
                  next_st.glyph_sel = 1'b0;
                  next_st.disp_off  = 7'h00;
                  next_st.wait_cnt  = 17'(CLEAR_CYC - 1);
               end
               8'b00000001:
               begin
                  next_st.phase     = char_lcd_pkg::PH_CLEAR;
                  next_st.clr_idx   = 7'h00;
                  next_st.ptr       = char_lcd_pkg::HOME_ADDR;
                  next_st.glyph_sel = 1'b0;
                  next_st.disp_off  = 7'h00;
                  next_st.inc       = 1'b1;
                  next_st.wait_cnt  = 17'(CLEAR_CYC - 1);
               end
               default:
               begin
                  next_st.phase = char_lcd_pkg::PH_IDLE;
               end
            endcase
         end
      end

      // Cursor blink timer
      if (!st.blink_en)
      begin
         next_st.blink_cnt = 25'h0;
         next_st.blink_ph  = 1'b0;
      end
      else if (st.blink_cnt == 25'(BLINK_CYC - 1))
      begin
         next_st.blink_cnt = 25'h0;
         next_st.blink_ph  = ~st.blink_ph;
      end
      else
         next_st.blink_cnt = st.blink_cnt + 25'h1;

      next_st.disp_char = text_ram[disp_addr];
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st          <= '0;
         st.phase    <= char_lcd_pkg::PH_IDLE;
         st.inc      <= char_lcd_pkg::INC_RESET;
         st.width8   <= char_lcd_pkg::WIDTH_RESET;
         st.duty     <= char_lcd_pkg::DUTY_RESET;
         st.cs_s1    <= 1'b1;
         st.cs_s2    <= 1'b1;
      end
      else
         st <= next_st;
   end

   always_ff @(posedge clk_i)
   begin
      if (ram_we && ram_glyph)
         glyph_ram[ram_addr[5:0]] <= ram_wdata;
      else if (ram_we)
         text_ram[ram_addr] <= ram_wdata;
   end

   // ==========================================================
   // Outputs
   assign wb_dat_o      = st.rdata;
   assign wb_ack_o      = st.ack;
   assign disp_char_o   = st.disp_char;
   assign cursor_addr_o = st.ptr;
   assign display_on_o  = st.disp_on;
   assign cursor_on_o   = st.cur_on;
   assign blink_phase_o = st.blink_ph;
   assign duty_o        = st.duty;
   assign busy_flag_o   = st.phase != char_lcd_pkg::PH_IDLE;

endmodule

// ---- char_lcd_instruction_decoder_sva.sv ----
`timescale 1ns/1ps
module char_lcd_checker #(
   parameter int CLEAR_CYC = 300,
   parameter int BLINK_CYC = 20
)(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        chip_select_n_i,
   input wire logic [6:0]  cursor_addr_o,
   input wire logic        display_on_o,
   input wire logic        cursor_on_o,
   input wire logic [4:0]  duty_o,
   input wire logic        busy_flag_o
);
   localparam int EXEC = int'(char_lcd_pkg::EXEC_CYC);
   int busy_len;

   // ==========================================================
   // Length of the current busy stretch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         busy_len <= 0;
      else
         busy_len <= busy_flag_o ? busy_len + 1 : 0;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_instr;
      s_take ##0 (wb_we_i && wb_sel_i[0] && !busy_flag_o
                  && wb_adr_i == 4'h0);
   endsequence

   // ==========================================================
   // Properties
   AST_ACK_TAKE:
   assert property (s_take |=> wb_ack_o)
      else $error("ack missing after a taken request");
   AST_ACK_PULSE:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_STATUS:
   assert property (s_take ##0 (!wb_we_i && wb_adr_i == 4'h0) |=>
      wb_dat_o[7:0] == {$past(busy_flag_o), $past(cursor_addr_o)})
      else $error("status read does not match busy and pointer");
   AST_CLEAR:
   assert property (s_instr ##0 wb_dat_i[7:0] == 8'h01 |=>
      busy_flag_o && cursor_addr_o == 7'h00)
      else $error("clear did not zero pointer and go busy");
   AST_HOME:
   assert property (s_instr ##0 wb_dat_i[7:1] == 7'h01 |=>
      busy_flag_o && cursor_addr_o == 7'h00)
      else $error("home did not zero pointer and go busy");
   AST_TEXT_ADDR:
   assert property (s_instr ##0 wb_dat_i[7] |=>
      cursor_addr_o == $past(wb_dat_i[6:0]))
      else $error("text address not loaded");
   AST_GLYPH_ADDR:
   assert property (s_instr ##0 wb_dat_i[7:6] == 2'b01 |=>
      cursor_addr_o[5:0] == $past(wb_dat_i[5:0]))
      else $error("glyph address not loaded");
   AST_DISP_CTRL:
   assert property (s_instr ##0 wb_dat_i[7:3] == 5'h01 |=>
      display_on_o == $past(wb_dat_i[2])
      && cursor_on_o == $past(wb_dat_i[1]))
      else $error("display or cursor enable wrong");
   AST_DUTY:
   assert property (s_instr ##0 wb_dat_i[7:5] == 3'h1 |=>
      duty_o == ($past(wb_dat_i[3]) ? 5'h10 :
                 $past(wb_dat_i[2]) ? 5'h0B : 5'h08))
      else $error("duty does not follow line and font bits");
   AST_BUSY_LEN:
   assert property ($fell(busy_flag_o) |-> busy_len inside
      {[EXEC-1:EXEC+1], [CLEAR_CYC-1:CLEAR_CYC+1]})
      else $error("busy stretch has wrong length");
   AST_CS_IDLE:
   assert property ((chip_select_n_i && !wb_stb_i)[*8] |->
      $stable(cursor_addr_o))
      else $error("pointer moved while deselected and idle");
endmodule

bind char_lcd_instruction_decoder char_lcd_checker #(
   .CLEAR_CYC(CLEAR_CYC),
   .BLINK_CYC(BLINK_CYC)
) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .chip_select_n_i(chip_select_n_i),
   .cursor_addr_o(cursor_addr_o), .display_on_o(display_on_o),
   .cursor_on_o(cursor_on_o), .duty_o(duty_o),
   .busy_flag_o(busy_flag_o)
);

// ---- char_lcd_serial_host.sv ----
`timescale 1ns/1ps
module char_lcd_serial_host (
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdo_o
);
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdo_o  = 1'b0;
   end

   // ==========================================================
   // One frame; sel low keeps the device deselected
   task automatic send(input logic rs, input logic [7:0] d,
                       input bit sel);
      logic [8:0] f;
      f = {rs, d};
      cs_n_o = !sel;
      #80;
      for (int i = 8; i >= 0; i--)
      begin
         sdo_o = f[i];
         #80 sclk_o = 1'b1;
         #80 sclk_o = 1'b0;
      end
      #80;
      cs_n_o = 1'b1;
      sdo_o  = ~sdo_o;
   endtask
endmodule

// ---- char_lcd_instruction_decoder_bench.sv ----
`timescale 1ns/1ps
module char_lcd_instruction_decoder_bench;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc   = 1'b0;
   logic        wb_stb   = 1'b0;
   logic        wb_we    = 1'b0;
   logic [3:0]  wb_adr   = 4'h0;
   logic [3:0]  wb_sel   = 4'hF;
   logic [31:0] wb_dat   = 32'h0;
   logic        disp_row = 1'b0;
   logic [3:0]  disp_col = 4'h0;
   wire logic   cs_n, sclk, sdo, ack, busy, dsp_on, cur_on, blink;
   wire logic [31:0] dat_o;
   wire logic [7:0]  disp_char;
   wire logic [6:0]  cur_addr;
   wire logic [4:0]  duty;
   logic [31:0] rd;
   int          n_mismatch = 0;
   int          checks     = 0;
   int          ram [128];
   int          ptr;
   int          inc;
   int          b;

   always #5 clk_i = ~clk_i;

   char_lcd_serial_host host_u (.cs_n_o(cs_n), .sclk_o(sclk),
      .sdo_o(sdo));
   char_lcd_instruction_decoder #(.CLEAR_CYC(300), .BLINK_CYC(20)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .chip_select_n_i(cs_n), .serial_clk_i(sclk), .serial_in_i(sdo),
      .disp_row_i(disp_row), .disp_col_i(disp_col),
      .disp_char_o(disp_char), .cursor_addr_o(cur_addr),
      .display_on_o(dsp_on), .cursor_on_o(cur_on), .blink_phase_o(blink),
      .duty_o(duty), .busy_flag_o(busy));

   // ==========================================================
   // Tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wb(logic w, logic [3:0] a, logic [7:0] d,
                     logic [3:0] s = 4'hF);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_sel <= s;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         finish_test;
      end
   endtask

   task automatic idle;
      int n;
      n = 0;
      do
      begin
         wb(1'b0, 4'h0, 8'h00);
         n++;
      end while (rd[7] !== 1'b0 && n < 2000);
      if (rd[7] !== 1'b0)
      begin
         n_mismatch++;
         finish_test;
      end
   endtask

   task automatic cmd(logic [3:0] a, logic [7:0] d);
      wb(1'b1, a, d);
      idle;
   endtask

   function automatic int nxt(int p);
      if (p == 39 && inc > 0)
         return 64;
      if (p == 64 && inc < 0)
         return 39;
      return (p + inc) & 127;
   endfunction

   task automatic put;
      b = $urandom_range(255);
      cmd(4'h4, 8'(b));
      ram[ptr] = b;
      ptr = nxt(ptr);
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", ptr, rd[6:0]);
   endtask

   task automatic dchk(logic r, logic [3:0] c, int e);
      @(posedge clk_i);
      disp_row <= r;
      disp_col <= c;
      repeat (3) @(posedge clk_i);
      chk("disp_char", e, disp_char);
   endtask

   task automatic reset_chk;
      wb(1'b0, 4'h8, 8'h00);
      chk("config", 32'h28, rd);
      wb(1'b0, 4'h0, 8'h00);
      chk("status", 32'h0, rd);
      chk("duty", 8, duty);
      chk("display_on", 0, dsp_on);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(66));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_chk;
      cmd(4'h0, 8'h04);
      cmd(4'h0, 8'h01);
      foreach (ram[i]) ram[i] = 32;
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 0, rd[6:0]);
      wb(1'b0, 4'h8, 8'h00);
      chk("increment", 1, rd[3]);
      wb(1'b0, 4'h4, 8'h00);
      chk("space", 32'h20, rd[7:0]);
      idle;
      $display("test clear done");
      for (int i = 0; i < 4; i++)
      begin
         cmd(4'h0, 8'h30 | 8'(i << 2));
         chk("duty", i[1] ? 16 : i[0] ? 11 : 8, duty);
         wb(1'b0, 4'h8, 8'h00);
         chk("font", i[0], rd[7]);
      end
      for (int i = 0; i < 8; i++)
      begin
         cmd(4'h0, 8'h08 | 8'(i));
         wb(1'b0, 4'h8, 8'h00);
         chk("display", {i[0], i[1], i[2]}, rd[2:0]);
         chk("enables", {i[2], i[1]}, {dsp_on, cur_on});
      end
      b = blink;
      repeat (20) @(posedge clk_i);
      chk("blink", b ^ 1, blink);
      $display("test modes done");
      inc = 1;
      cmd(4'h0, 8'h06);
      for (int s = 0; s < 2; s++)
      begin
         ptr = s ? 38 : 0;
         cmd(4'h0, 8'h80 | 8'(ptr));
         for (int k = 0; k < 2 + s; k++)
            put;
      end
      cmd(4'h0, 8'h04);
      inc = -1;
      put;
      put;
      inc = 1;
      cmd(4'h0, 8'h06);
      ptr = 38;
      cmd(4'h0, 8'h80 | 8'(ptr));
      for (int k = 0; k < 4; k++)
      begin
         wb(1'b0, 4'h4, 8'h00);
         chk("text", ram[ptr], rd[7:0]);
         ptr = nxt(ptr);
         idle;
      end
      dchk(1'b0, 4'h0, ram[0]);
      dchk(1'b1, 4'h1, ram[65]);
      $display("test text done");
      cmd(4'h0, 8'h81);
      cmd(4'h0, 8'h14);
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 2, rd[6:0]);
      cmd(4'h0, 8'h10);
      cmd(4'h0, 8'h18);
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 1, rd[6:0]);
      dchk(1'b0, 4'h0, ram[1]);
      cmd(4'h0, 8'h1C);
      dchk(1'b0, 4'h0, ram[0]);
      cmd(4'h0, 8'h18);
      cmd(4'h0, 8'h02);
      dchk(1'b0, 4'h1, ram[1]);
      cmd(4'h0, 8'h07);
      ptr = 0;
      put;
      dchk(1'b0, 4'h0, ram[1]);
      wb(1'b0, 4'h4, 8'h00);
      chk("text", ram[1], rd[7:0]);
      idle;
      dchk(1'b0, 4'h0, ram[1]);
      $display("test shift done");
      cmd(4'h0, 8'h45);
      b = $urandom_range(255);
      cmd(4'h4, 8'(b));
      cmd(4'h0, 8'h45);
      wb(1'b0, 4'h4, 8'h00);
      chk("glyph", b, rd[7:0]);
      idle;
      dchk(1'b0, 4'h0, ram[1]);
      cmd(4'h0, 8'h86);
      wb(1'b0, 4'h8, 8'h00);
      chk("glyph_sel", 0, rd[8]);
      wb(1'b1, 4'h4, 8'h5A);
      wb(1'b0, 4'h0, 8'h00);
      chk("busy", 1, rd[7]);
      chk("busy_flag", 1, busy);
      wb(1'b1, 4'h0, 8'h94);
      idle;
      wb(1'b1, 4'h0, 8'h94, 4'hE);
      wb(1'b1, 4'h8, 8'h00);
      wb(1'b0, 4'hC, 8'h00);
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 7, rd[6:0]);
      wb(1'b0, 4'h8, 8'h00);
      chk("config", 32'hFF, rd[7:0]);
      $display("test busy done");
      host_u.send(1'b0, 8'hC5, 1'b1);
      idle;
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 32'h45, rd[6:0]);
      b = $urandom_range(255);
      host_u.send(1'b1, 8'(b), 1'b1);
      idle;
      host_u.send(1'b0, 8'h80, 1'b0);
      wb(1'b0, 4'h0, 8'h00);
      chk("pointer", 32'h46, rd[6:0]);
      cmd(4'h0, 8'hC5);
      wb(1'b0, 4'h4, 8'h00);
      chk("serial_data", b, rd[7:0]);
      idle;
      host_u.send(1'b0, 8'h30, 1'b1);
      idle;
      chk("duty", 8, duty);
      $display("test serial done");
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_chk;
      $display("test reset done");
      finish_test;
   end
endmodule
